/* File: include/rcclc_params.svh */
`ifndef RCCLC_PARAMS_SVH
`define RCCLC_PARAMS_SVH

// register placement
`define RCC_REG_ADDR 32'h4000_0000

// field positions
`define RCC_PIN_BIT 0
`define RCC_CORE_BIT 1
`define RCC_HANG_BIT 2
`define RCC_DBG_BIT 3
`define RCC_ALLOWED_BIT 7
`define RCC_HKEY_LSB 0
`define RCC_HKEY_MSB 7
`define RCC_DKEY_LSB 16
`define RCC_DKEY_MSB 23

// keys
`define RCC_HANG_KEY 8'hc9
`define RCC_DBG_KEY 8'h3a

// reset values
`define RCC_CAUSE_RST 4'h1
`define RCC_ALLOWED_RST 1'b0

// timing: reset pulse length, least time, rounded up
`define RCC_CLK_MHZ 100
`define RCC_PULSE_NS 100
`define RCC_PULSE_CYC ((`RCC_PULSE_NS * `RCC_CLK_MHZ + 999) / 1000)

`endif

/* File: include/rcclc_pkg.sv */
package rcclc_pkg;

  // processor bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rcclc_bus_req_t;

  // recorded reset causes
  typedef struct packed {
    logic dbg;
    logic hang;
    logic core;
    logic pin;
  } rcclc_causes_t;

  // system reset pulse generator
  typedef enum logic [0:0] {
    RCC_IDLE = 1'b0,
    RCC_PULSE = 1'b1
  } rcclc_state_t;

endpackage

/* File: rtl/rcclc_top.sv */
`timescale 1ns/1ps
`include "rcclc_params.svh"
module rcclc_top
  import rcclc_pkg::*;
(
  // clock and power-on reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // processor bus
  input wire rcclc_bus_req_t bus_req_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_ack_o,
  // debug port write
  input wire logic dbg_wr_i,
  input wire logic [31:0] dbg_wdata_i,
  // reset sources
  input wire logic pin_reset_i,
  input wire logic core_reset_req_i,
  input wire logic hang_i,
  // system reset out and state
  output logic sys_reset_o,
  output rcclc_causes_t causes_o,
  output logic hang_reset_allowed_o
);

  localparam logic [3:0] PULSE_CYC = 4'(`RCC_PULSE_CYC);

  rcclc_causes_t cause_reg, cause_next;
  logic allowed_reg, allowed_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  rcclc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic sysrst_reg, sysrst_next;

  logic hit;
  logic rd_hit;
  logic wr_hit;
  logic dbg_key_hit;
  logic hang_trig;
  logic any_src;
  logic trigger;
  logic [31:0] read_word;

  assign hit = (bus_req_i.addr == `RCC_REG_ADDR);
  assign rd_hit = hit && bus_req_i.rd;
  assign wr_hit = hit && bus_req_i.wr;
  assign dbg_key_hit = dbg_wr_i &&
    (dbg_wdata_i[`RCC_DKEY_MSB:`RCC_DKEY_LSB] == `RCC_DBG_KEY);
  assign hang_trig = hang_i && allowed_reg;
  assign any_src = pin_reset_i || core_reset_req_i || hang_trig || dbg_key_hit;
  assign trigger = core_reset_req_i || hang_trig || dbg_key_hit;

  // register read image; key fields are write-only
  always_comb begin
    read_word = 32'h0000_0000;
    read_word[`RCC_PIN_BIT] = cause_reg.pin;
    read_word[`RCC_CORE_BIT] = cause_reg.core;
    read_word[`RCC_HANG_BIT] = cause_reg.hang;
    read_word[`RCC_DBG_BIT] = cause_reg.dbg;
    read_word[`RCC_ALLOWED_BIT] = allowed_reg;
  end

  // cause flags and lockup allowance
  always_comb begin
    cause_next = cause_reg;
    allowed_next = allowed_reg;
    if (rd_hit) begin
      cause_next = '0;
    end
    // set after clear so a fresh cause wins
    if (pin_reset_i) begin
      cause_next.pin = 1'b1;
    end
    if (core_reset_req_i) begin
      cause_next.core = 1'b1;
    end
    if (hang_trig) begin
      cause_next.hang = 1'b1;
    end
    if (dbg_key_hit) begin
      cause_next.dbg = 1'b1;
    end
    if (wr_hit) begin
      // bits 23:16 of a core write are not looked at
      allowed_next = (bus_req_i.wdata[`RCC_HKEY_MSB:`RCC_HKEY_LSB] ==
        `RCC_HANG_KEY);
    end
    if (any_src) begin
      allowed_next = 1'b0;
    end
  end

  // of the resets only rst_n_i loads these; system resets leave them
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cause_reg <= `RCC_CAUSE_RST;
      allowed_reg <= `RCC_ALLOWED_RST;
    end else begin
      cause_reg <= cause_next;
      allowed_reg <= allowed_next;
    end
  end

  // bus answer, one cycle after the access
  always_comb begin
    ack_next = hit && (bus_req_i.rd || bus_req_i.wr);
    rdata_next = rd_hit ? read_word : 32'h0000_0000;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // system reset pulse; triggers during a pulse do not extend it
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sysrst_next = 1'b0;
    case (state_reg)
      RCC_IDLE: begin
        if (trigger) begin
          state_next = RCC_PULSE;
          cnt_next = PULSE_CYC - 4'h1;
          sysrst_next = 1'b1;
        end
      end
      RCC_PULSE: begin
        if (cnt_reg == 4'h0) begin
          state_next = RCC_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
          sysrst_next = 1'b1;
        end
      end
      default: begin
        state_next = RCC_IDLE;
        cnt_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= RCC_IDLE;
      cnt_reg <= 4'h0;
      sysrst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sysrst_reg <= sysrst_next;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign bus_ack_o = ack_reg;
  assign sys_reset_o = sysrst_reg;
  assign causes_o = cause_reg;
  assign hang_reset_allowed_o = allowed_reg;

  // checks
  logic past_valid_reg;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      past_valid_reg <= 1'b0;
    end else begin
      past_valid_reg <= 1'b1;
    end
  end

  property p_pin_flag;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pin_reset_i |=> causes_o.pin;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin reset not recorded");

  property p_pin_after_por;
    @(posedge core_clk_i)
    $rose(rst_n_i) |-> causes_o.pin && !hang_reset_allowed_o;
  endproperty
  a_pin_after_por: assert property (p_pin_after_por) else $error("bad reset value");

  property p_core_flag;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    core_reset_req_i |=> causes_o.core && (sys_reset_o || $past(state_reg) == RCC_PULSE);
  endproperty
  a_core_flag: assert property (p_core_flag) else $error("core request not recorded");

  property p_hang_flag;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    past_valid_reg && $rose(causes_o.hang) |-> $past(hang_i) && $past(hang_reset_allowed_o);
  endproperty
  a_hang_flag: assert property (p_hang_flag) else $error("lockup flag without cause");

  property p_dbg_flag;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    dbg_wr_i && dbg_wdata_i[23:16] == 8'h3a |=> causes_o.dbg;
  endproperty
  a_dbg_flag: assert property (p_dbg_flag) else $error("debug reset not recorded");

  property p_read_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_hit && !any_src |=> causes_o == 4'h0 ##0 bus_ack_o;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_read_image;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_hit |=> bus_rdata_o[7] == $past(hang_reset_allowed_o)
      && bus_rdata_o[3:0] == $past(causes_o);
  endproperty
  a_read_image: assert property (p_read_image) else $error("read image wrong");

  property p_key_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_hit && !any_src |=> hang_reset_allowed_o == ($past(bus_req_i.wdata[7:0]) == 8'hc9);
  endproperty
  a_key_write: assert property (p_key_write) else $error("lockup key handling wrong");

  property p_src_clears;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    any_src |=> !hang_reset_allowed_o;
  endproperty
  a_src_clears: assert property (p_src_clears) else $error("allowance not cleared");

  // length of the current system reset pulse, for the check below
  logic [3:0] pulse_len_reg, pulse_len_next;
  always_comb begin
    pulse_len_next = 4'h0;
    if (sys_reset_o) begin
      pulse_len_next = pulse_len_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pulse_len_reg <= 4'h0;
    end else begin
      pulse_len_reg <= pulse_len_next;
    end
  end

  property p_pulse_len;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pulse_len_reg <= PULSE_CYC &&
      (sys_reset_o || pulse_len_reg == 4'h0 || pulse_len_reg == PULSE_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_core_no_key;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == RCC_IDLE && wr_hit && !trigger |=> !sys_reset_o && !$rose(causes_o.dbg);
  endproperty
  a_core_no_key: assert property (p_core_no_key)
    else $error("core write triggered reset");

  property p_zero_bits;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    bus_rdata_o[31:24] == 8'h00 && bus_rdata_o[15:8] == 8'h00 && bus_rdata_o[6:4] == 3'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");

  property p_set_wins;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_hit && core_reset_req_i |=> causes_o.core;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("cause lost to read");

  property p_hang_ignored;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    hang_i && !hang_reset_allowed_o |=> !$rose(causes_o.hang);
  endproperty
  a_hang_ignored: assert property (p_hang_ignored) else $error("lockup not barred");

  property p_ack_resp;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    hit && (bus_req_i.rd || bus_req_i.wr) |=> bus_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("access not acknowledged");

  property p_idle_bus;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(hit && (bus_req_i.rd || bus_req_i.wr)) |=> !bus_ack_o && bus_rdata_o == 32'h0000_0000;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("stray bus answer");

  c_dbg_reset: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dbg_key_hit ##1 sys_reset_o);
  c_hang_reset: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hang_trig ##1 causes_o.hang);
  c_key_arm: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(hang_reset_allowed_o));
  c_clear_race: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_hit && pin_reset_i);

endmodule

/* File: tb/rcclc_partner.sv */
`timescale 1ns/1ps
module rcclc_partner (
  // clock
  input wire logic core_clk_i,
  // bench commands, bit 0 pin, 1 core, 2 hang, 3 debug
  input wire logic [3:0] fire_i,
  input wire logic [7:0] key_i,
  // reset sources and debug port
  output logic pin_reset_o = 1'b0,
  output logic core_reset_req_o = 1'b0,
  output logic hang_o = 1'b0,
  output logic dbg_wr_o = 1'b0,
  output logic [31:0] dbg_wdata_o = 32'h0000_0000
);
  // one-cycle events, changed off the sampling edge
  always @(negedge core_clk_i) begin
    {dbg_wr_o, hang_o, core_reset_req_o, pin_reset_o} <= fire_i;
    // key only while the strobe is up, a toggling pattern otherwise
    dbg_wdata_o <= fire_i[3] ? {8'h00, key_i, 16'h0000} : ~dbg_wdata_o;
  end
endmodule

/* File: tb/test_reset_cause_and_lockup_control.sv */
`timescale 1ns/1ps
`include "rcclc_params.svh"
module test_reset_cause_and_lockup_control;
  import rcclc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rcclc_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic bus_ack, sys_reset, allowed, dbg_wr, pin_rst, core_req, hang;
  logic [31:0] dbg_wdata;
  rcclc_causes_t causes;
  logic [3:0] fire = 4'h0;
  logic [7:0] key = 8'h00;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] r;
  int bad_count = 0;
  int checks_done = 0;
  localparam logic [31:0] RA = `RCC_REG_ADDR;

  always #5 core_clk_i = ~core_clk_i;

  rcclc_top u_rcclc_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req),
    .bus_rdata_o(bus_rdata), .bus_ack_o(bus_ack), .dbg_wr_i(dbg_wr), .dbg_wdata_i(dbg_wdata),
    .pin_reset_i(pin_rst), .core_reset_req_i(core_req), .hang_i(hang),
    .sys_reset_o(sys_reset), .causes_o(causes), .hang_reset_allowed_o(allowed));

  rcclc_partner u_rcclc_partner (.core_clk_i(core_clk_i), .fire_i(fire), .key_i(key),
    .pin_reset_o(pin_rst), .core_reset_req_o(core_req), .hang_o(hang),
    .dbg_wr_o(dbg_wr), .dbg_wdata_o(dbg_wdata));

  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  task automatic bus(input logic rd, input logic wr, input logic [31:0] a, wd, ex);
    @(negedge core_clk_i);
    bus_req <= {rd, wr, a, wd};
    if (a == RA) exp_q.push_back({rd, ex});
    @(negedge core_clk_i);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [31:0] ex);
    bus(1'b1, 1'b0, RA, 32'h0, ex);
  endtask

  task automatic wr(input logic [31:0] wd);
    bus(1'b0, 1'b1, RA, wd, 32'h0);
  endtask

  task automatic send(input logic [3:0] f);
    @(posedge core_clk_i);
    fire <= f;
    @(posedge core_clk_i);
    fire <= 4'h0;
  endtask

  task automatic pulse(input int ex);
    int c;
    c = 0;
    repeat (16) begin
      @(negedge core_clk_i);
      if (sys_reset === 1'b1) c++;
    end
    chk(ex, c);
  endtask

  // every ack must match an outstanding access
  always @(negedge core_clk_i) begin
    if (bus_ack === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        if (e[32]) chk(e[31:0], bus_rdata);
      end
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(59));
    repeat (3) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    rd(32'h1);
    rd(32'h0);
    r = $urandom;
    // software key write also aims the debug key field at the core side
    wr({r[31:24], `RCC_DBG_KEY, r[15:8], `RCC_HANG_KEY});
    pulse(0);
    chk(32'h10, {27'h0, allowed, causes});
    rd(32'h80);
    rd(32'h80);
    r = $urandom;
    if (r[7:0] == `RCC_HANG_KEY) r[0] = ~r[0];
    wr(r);
    rd(32'h0);
    send(4'h4);
    pulse(0);
    rd(32'h0);
    key = `RCC_DBG_KEY;
    for (int i = 0; i < 4; i++) begin
      wr({24'h0, `RCC_HANG_KEY});
      send(4'h1 << i);
      pulse(i == 0 ? 0 : `RCC_PULSE_CYC);
      chk(32'h1 << i, {27'h0, allowed, causes});
      rd(32'h1 << i);
    end
    key = `RCC_DBG_KEY ^ 8'h01;
    send(4'h8);
    pulse(0);
    rd(32'h0);
    // read and a new cause on the same edge
    fork
      send(4'h2);
      rd(32'h0);
    join
    rd(32'h2);
    // second power-on reset cuts the running pulse and drops the allowance
    wr({24'h0, `RCC_HANG_KEY});
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk(32'h1, {27'h0, allowed, causes});
    rd(32'h1);
    bus(1'b1, 1'b0, RA + 32'h4, 32'h0, 32'h0);
    repeat (4) @(negedge core_clk_i);
    chk(32'h0, exp_q.size());
    conclude();
  end
endmodule
